// *** test/pst_afe_model.sv ***
`timescale 1ns/1ps
// Front-end stand-in: comparators and GPIO inputs as the self-test sees them
module pst_afe_model (
  input wire logic [pst_pkg::NUM_CELLS-1:0] cell_open_in,
  input wire logic [pst_pkg::NUM_GPIO-1:0] gpio_pullup_in,
  input wire logic [3:0] cmp_test_in,
  input wire logic break_in,
  input wire logic [3:0] cmp_bad_in,
  output logic [pst_pkg::NUM_CELLS-1:0] cell_uv_out,
  output logic [pst_pkg::NUM_GPIO-1:0] gpio_ut_out,
  output logic [3:0] cmp_ok_out
);
  // cells sit clear of thresholds; an opened input reads undervoltage
  assign cell_uv_out = break_in ? '0 : cell_open_in;
  assign gpio_ut_out = break_in ? '0 : gpio_pullup_in;
  // comparator answers
  // Answers only under the test strobe, so a missing strobe shows as a fail
  assign cmp_ok_out = cmp_test_in & ~cmp_bad_in;
endmodule

// *** test/pst_top_tb.sv ***
`timescale 1ns/1ps
module pst_top_tb;
  import pst_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic seen = 1'b0;
  logic brk = 1'b0;
  logic foe;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [15:0] act = 16'h8001;
  logic [7:0] pull;
  logic [7:0] gut;
  logic [3:0] bad = 4'h0;
  logic [3:0] ok;
  logic [1:0] con;
  logic [15:0] copen;
  logic [15:0] cuv;
  logic [3:0] ctst;
  logic fol;
  logic [7:0] dac;
  int error_cnt = 0;
  int check_count = 0;

  // real overvoltage and overtemperature inputs stay quiet
  pst_top pst_top_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .cell_ov_in(16'h0000),
    .cell_uv_in(cuv), .gpio_ot_in(8'h00), .gpio_ut_in(gut), .cmp_ok_in(ok),
    .cell_active_in(act), .fault_seen_in(seen), .cell_open_out(copen),
    .gpio_pullup_out(pull), .cmp_test_out(ctst), .cmp_on_out(con), .aux_dac_out(dac),
    .fault_output_low_out(fol), .fault_output_low_oe_out(foe));
  pst_afe_model pst_afe_model_i (.cell_open_in(copen), .gpio_pullup_in(pull),
    .cmp_test_in(ctst), .break_in(brk), .cmp_bad_in(bad), .cell_uv_out(cuv),
    .gpio_ut_out(gut), .cmp_ok_out(ok));

  // 20 MHz clock
  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // Spare cycle after the strobe keeps back-to-back calls clean
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
    @(posedge clk_in);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata);
    @(posedge clk_in);
  endtask

  // Temperature go follows the voltage mode field, so that is set first
  task automatic run(input int k);
    int n;
    n = 0;
    wr(ADDR_VCTRL, (k == 1) ? 32'h4 : 32'h5);
    if (k == 1) wr(ADDR_TCTRL, 32'h5);
    // Look a step after the edge, once the powered flags have settled
    #1;
    while (con[k] !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 300) chk("run end", 32'h0, 32'h1);
    repeat (2) @(posedge clk_in);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rc(ADDR_STAT_B, 32'h0);
    rc(8'h20, 32'h0);
    rc(ADDR_OV_THR, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_dac();
    wr(ADDR_OV_THR, 32'h64);
    wr(ADDR_UV_THR, 32'h32);
    wr(ADDR_OT_THR, 32'h2A);
    wr(ADDR_VCTRL, 32'h7);
    wr(ADDR_DAC_SEL, 32'h0);
    rc(ADDR_DAC_RB, 32'h50);
    chk("aux dac", 32'h50, {24'h0, dac});
    wr(ADDR_DAC_SEL, 32'h1);
    rc(ADDR_DAC_RB, 32'h28);
    wr(ADDR_DAC_SEL, 32'h2);
    rc(ADDR_DAC_RB, 32'h2A);
    wr(ADDR_UT_THR, 32'h15);
    wr(ADDR_DAC_SEL, 32'h3);
    rc(ADDR_DAC_RB, 32'h15);
    $display("test dac done");
  endtask

  task automatic t_vbist();
    run(0);
    rc(ADDR_STAT_B, 32'h0);
    rc(ADDR_UV_BITS, 32'h0);
    rc(ADDR_OV_BITS, 32'h0);
    chk("cmp on", 32'h0, {31'h0, con[0]});
    chk("fault pin", 32'h0, {31'h0, foe});
    wr(ADDR_VCTRL, 32'h3);
    chk("rr on", 32'h1, {31'h0, con[0]});
    $display("test voltage self-test done");
  endtask

  // Each comparator broken in turn, volt pair then temp pair
  task automatic t_cmp();
    for (int k = 0; k < 4; k++) begin
      bad <= 4'h1 << k;
      run(k / 2);
      rc(ADDR_STAT_B, 32'h1 << k);
      chk("temp cmp on", 32'h0, {31'h0, con[1]});
      wr(ADDR_DIAG, 32'h2);
    end
    bad <= 4'h0;
    $display("test comparators done");
  endtask

  task automatic t_fail();
    seen <= 1'b1;
    run(0);
    rc(ADDR_STAT_B, 32'h40);
    seen <= 1'b0;
    wr(ADDR_DIAG, 32'h2);
    brk <= 1'b1;
    run(1);
    rc(ADDR_STAT_B, 32'h20);
    brk <= 1'b0;
    wr(ADDR_DIAG, 32'h2);
    $display("test abort and path done");
  endtask

  task automatic t_go();
    wr(ADDR_VCTRL, 32'h5);
    wr(ADDR_VCTRL, 32'h3);
    repeat (100) @(posedge clk_in);
    chk("go mid run", 32'h1, {31'h0, con[0]});
    wr(ADDR_TCTRL, 32'h3);
    chk("temp rr on", 32'h1, {31'h0, con[1]});
    $display("test go mid run done");
  endtask

  // Kept fault bits have no software clear, so this runs last
  task automatic t_keep();
    wr(ADDR_DIAG, 32'h1);
    run(0);
    rc(ADDR_UV_BITS, 32'h8001);
    rc(ADDR_OV_BITS, 32'hFFFF);
    chk("kept pin", 32'h1, {31'h0, foe});
    chk("pin level", 32'h0, {31'h0, fol});
    $display("test keep faults done");
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_dac();
    t_vbist();
    t_cmp();
    t_fail();
    t_go();
    t_keep();
    tally_and_finish();
  end

  // Whole run is under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule

// *** verilog/pst_pkg.sv ***
package pst_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_CELLS = 16;
  localparam int NUM_GPIO = 8;
  localparam int THR_W = 8;

  // ----------------------------------------------------------------------
  // Register offsets (8-bit index space)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_VCTRL = 8'h00;   // voltage_protector_control
  localparam logic [7:0] ADDR_TCTRL = 8'h01;   // temperature_protector_control
  localparam logic [7:0] ADDR_DIAG = 8'h02;    // protector_diag_control
  localparam logic [7:0] ADDR_OV_THR = 8'h03;
  localparam logic [7:0] ADDR_UV_THR = 8'h04;
  localparam logic [7:0] ADDR_OT_THR = 8'h05;
  localparam logic [7:0] ADDR_UT_THR = 8'h06;
  localparam logic [7:0] ADDR_STAT_A = 8'h07;  // protector_fault_status_a
  localparam logic [7:0] ADDR_STAT_B = 8'h08;  // protector_fault_status_b
  localparam logic [7:0] ADDR_UV_BITS = 8'h09;
  localparam logic [7:0] ADDR_OV_BITS = 8'h0A;
  localparam logic [7:0] ADDR_UTOT_BITS = 8'h0B;
  localparam logic [7:0] ADDR_DAC_RB = 8'h0C;
  localparam logic [7:0] ADDR_DAC_SEL = 8'h0D;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_GO_BIT = 0;      // go, self-clearing
  localparam int CTRL_MODE_LSB = 1;    // mode[1:0] at bits 2:1
  localparam int CTRL_LOCK_LSB = 3;    // lock at bits 6:3
  localparam int DIAG_KEEP_BIT = 0;
  localparam int DIAG_CLR_BIT = 1;     // clears fail flags, self-clearing
  localparam int SA_VPAR_BIT = 0;
  localparam int SA_TPAR_BIT = 1;
  localparam int SB_OVC_BIT = 0;
  localparam int SB_UVC_BIT = 1;
  localparam int SB_OTC_BIT = 2;
  localparam int SB_UTC_BIT = 3;
  localparam int SB_VPATH_BIT = 4;
  localparam int SB_TPATH_BIT = 5;
  localparam int SB_ABORT_BIT = 6;

  // ----------------------------------------------------------------------
  // Modes, reset values, timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RR = 2'h1;
  localparam logic [1:0] MODE_BIST = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  localparam logic [THR_W-1:0] THR_RST = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam int DAC_SCALE_NUM = 4;    // 0.8 = 4/5
  localparam int DAC_SCALE_DEN = 5;
  localparam int CHK_PERIOD_NS = 800;  // background parity check period
  localparam int CLK_PERIOD_NS = 50;
  localparam int CHK_CYCLES = CHK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_COMP = 6'h02,
    ST_PRE = 6'h04,
    ST_PATH = 6'h08,
    ST_FORCE = 6'h10,
    ST_DONE = 6'h20
  } pst_state_e;

  typedef struct packed {
    logic [THR_W-1:0] hi;
    logic [THR_W-1:0] lo;
    logic parity;
  } pst_latch_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pst_bus_s;

endpackage

// *** verilog/pst_top.sv ***
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Enabling a protector latches its threshold settings into the protector.
// - Latched settings are rechecked periodically in the background while running.
// - Voltage mismatch sets voltage parity fail; temperature mismatch sets temperature.
// - Threshold DAC values are multiplexed to the auxiliary ADC for readback.
// - Overvoltage and undervoltage readback equal 0.8 times the threshold setting.
// - Voltage mode 0b10 with go starts the voltage self-test.
// - Voltage comparators checked above and below threshold; failures set flags.
// - Each active cell (cell_active_in) is forced undervoltage; bit and fault output checked, cleared.
// - Each overvoltage bit is forced in turn; bit and fault output checked.
// - Voltage test end turns comparators off; go with 0b01 resumes.
// - A go during a self-test acts at once per current mode.
// - A fault seen before the path step aborts and sets abort flag.
// - Keep-faults bit leaves tested fault bits and fault output asserted.
// - Temperature go with voltage mode field 0b10 starts the temperature self-test.
// - Temperature comparators checked above and below threshold; failures set flags.
// - Each GPIO is pulled up forcing undertemperature; bit and output checked.
// - Each overtemperature bit is forced in turn and checked.
// - Temperature test end turns comparators off; go with voltage mode field 0b01 resumes.
module pst_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [pst_pkg::NUM_CELLS-1:0] cell_ov_in,
  input wire logic [pst_pkg::NUM_CELLS-1:0] cell_uv_in,
  input wire logic [pst_pkg::NUM_GPIO-1:0] gpio_ot_in,
  input wire logic [pst_pkg::NUM_GPIO-1:0] gpio_ut_in,
  input wire logic [3:0] cmp_ok_in,
  input wire logic [pst_pkg::NUM_CELLS-1:0] cell_active_in,
  input wire logic fault_seen_in,
  output logic [pst_pkg::NUM_CELLS-1:0] cell_open_out,
  output logic [pst_pkg::NUM_GPIO-1:0] gpio_pullup_out,
  output logic [3:0] cmp_test_out,
  output logic [1:0] cmp_on_out,
  output logic [pst_pkg::THR_W-1:0] aux_dac_out,
  output logic fault_output_low_out,
  output logic fault_output_low_oe_out
);
  import pst_pkg::*;

  // ----------------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------------
  pst_bus_s bus;
  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  wire wr_vctrl = bus.wr && (bus.addr == ADDR_VCTRL);
  wire wr_tctrl = bus.wr && (bus.addr == ADDR_TCTRL);
  wire wr_diag = bus.wr && (bus.addr == ADDR_DIAG);
  wire v_go = wr_vctrl && bus.wdata[CTRL_GO_BIT];
  wire t_go = wr_tctrl && bus.wdata[CTRL_GO_BIT];
  wire [1:0] v_mode_w = bus.wdata[CTRL_MODE_LSB +: 2];
  wire fail_clr = wr_diag && bus.wdata[DIAG_CLR_BIT];

  logic [6:0] vctrl_r, tctrl_r;
  logic keep_r;
  logic [THR_W-1:0] ov_thr_r, uv_thr_r, ot_thr_r, ut_thr_r;
  logic [1:0] dac_sel_r;

  // Control and threshold registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vctrl_r <= 7'h00;
      tctrl_r <= 7'h00;
      keep_r <= 1'b0;
      ov_thr_r <= THR_RST;
      uv_thr_r <= THR_RST;
      ot_thr_r <= THR_RST;
      ut_thr_r <= THR_RST;
      dac_sel_r <= 2'h0;
    end else if (bus.wr) begin
      if (wr_vctrl) vctrl_r <= {bus.wdata[6:1], 1'b0};
      if (wr_tctrl) tctrl_r <= {bus.wdata[6:1], 1'b0};
      if (wr_diag) keep_r <= bus.wdata[DIAG_KEEP_BIT];
      if (bus.addr == ADDR_OV_THR) ov_thr_r <= bus.wdata[THR_W-1:0];
      if (bus.addr == ADDR_UV_THR) uv_thr_r <= bus.wdata[THR_W-1:0];
      if (bus.addr == ADDR_OT_THR) ot_thr_r <= bus.wdata[THR_W-1:0];
      if (bus.addr == ADDR_UT_THR) ut_thr_r <= bus.wdata[THR_W-1:0];
      if (bus.addr == ADDR_DAC_SEL) dac_sel_r <= bus.wdata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Protector run state and latched settings
  // ----------------------------------------------------------------------
  logic [1:0] v_run_r, t_run_r;
  pst_latch_s v_lat_r, t_lat_r;
  pst_state_e v_st_r, t_st_r;
  wire v_en = (v_run_r != MODE_OFF);
  wire t_en = (t_run_r != MODE_OFF);
  wire v_done = (v_st_r == ST_DONE);
  wire t_done = (t_st_r == ST_DONE);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      v_run_r <= MODE_OFF;
      t_run_r <= MODE_OFF;
      v_lat_r <= '0;
      t_lat_r <= '0;
    end else begin
      if (v_go) begin
        v_run_r <= v_mode_w;
        v_lat_r <= '{hi: ov_thr_r, lo: uv_thr_r, parity: ^{ov_thr_r, uv_thr_r}};
      end else if (v_done) begin
        v_run_r <= MODE_OFF;
      end
      // Temperature go follows the voltage mode field, as the part does
      if (t_go) begin
        t_run_r <= vctrl_r[CTRL_MODE_LSB +: 2];
        t_lat_r <= '{hi: ot_thr_r, lo: ut_thr_r, parity: ^{ot_thr_r, ut_thr_r}};
      end else if (t_done) begin
        t_run_r <= MODE_OFF;
      end
    end
  end

  logic [7:0] chk_cnt_r;
  wire chk_tick = (chk_cnt_r == 8'(CHK_CYCLES - 1));
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) chk_cnt_r <= 8'h00;
    else chk_cnt_r <= chk_tick ? 8'h00 : chk_cnt_r + 8'h01;
  end

  wire v_par_bad = chk_tick && v_en && (^{v_lat_r.hi, v_lat_r.lo} != v_lat_r.parity);
  wire t_par_bad = chk_tick && t_en && (^{t_lat_r.hi, t_lat_r.lo} != t_lat_r.parity);

  // ----------------------------------------------------------------------
  // Self-test engines (one per protector, shared shape)
  // ----------------------------------------------------------------------
  logic [3:0] v_ch_r;
  logic [2:0] t_ch_r;
  logic v_ph_r, t_ph_r;          // 0 = force, 1 = check
  logic [NUM_CELLS-1:0] uv_bits_r, ov_bits_r;
  logic [NUM_GPIO-1:0] ut_bits_r, ot_bits_r;
  logic [6:0] stat_b_r;
  logic [1:0] stat_a_r;
  wire v_bist = (v_st_r != ST_IDLE) && (v_st_r != ST_DONE);
  wire t_bist = (t_st_r != ST_IDLE) && (t_st_r != ST_DONE);
  wire v_start = v_go && (v_mode_w == MODE_BIST);
  wire t_start = t_go && (vctrl_r[CTRL_MODE_LSB +: 2] == MODE_BIST);
  wire v_last = (v_ch_r == 4'(NUM_CELLS - 1));
  wire t_last = (t_ch_r == 3'(NUM_GPIO - 1));
  wire fault_any = (|uv_bits_r) || (|ov_bits_r) || (|ut_bits_r) || (|ot_bits_r);

  // Voltage engine sequencing
  // start on mode 0b10
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      v_st_r <= ST_IDLE;
      v_ch_r <= 4'h0;
      v_ph_r <= 1'b0;
    end else if (v_go) begin
      v_st_r <= v_start ? ST_COMP : ST_IDLE;
      v_ch_r <= 4'h0;
      v_ph_r <= 1'b0;
    end else begin
      case (v_st_r)
        ST_IDLE: v_st_r <= ST_IDLE;
        ST_COMP: v_st_r <= ST_PRE;
        ST_PRE: v_st_r <= fault_seen_in ? ST_DONE : ST_PATH;
        ST_PATH, ST_FORCE: begin
          v_ph_r <= ~v_ph_r;
          if (v_ph_r) begin
            v_ch_r <= v_last ? 4'h0 : v_ch_r + 4'h1;
            if (v_last) v_st_r <= (v_st_r == ST_PATH) ? ST_FORCE : ST_DONE;
          end
        end
        ST_DONE: v_st_r <= ST_IDLE;
        default: v_st_r <= ST_IDLE;
      endcase
    end
  end

  // Temperature engine sequencing
  // start on mode 0b10
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      t_st_r <= ST_IDLE;
      t_ch_r <= 3'h0;
      t_ph_r <= 1'b0;
    end else if (t_go) begin
      t_st_r <= t_start ? ST_COMP : ST_IDLE;
      t_ch_r <= 3'h0;
      t_ph_r <= 1'b0;
    end else begin
      case (t_st_r)
        ST_IDLE: t_st_r <= ST_IDLE;
        ST_COMP: t_st_r <= ST_PRE;
        ST_PRE: t_st_r <= fault_seen_in ? ST_DONE : ST_PATH;
        ST_PATH, ST_FORCE: begin
          t_ph_r <= ~t_ph_r;
          if (t_ph_r) begin
            t_ch_r <= t_last ? 3'h0 : t_ch_r + 3'h1;
            if (t_last) t_st_r <= (t_st_r == ST_PATH) ? ST_FORCE : ST_DONE;
          end
        end
        ST_DONE: t_st_r <= ST_IDLE;
        default: t_st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fault bits: real monitoring or engine forcing
  // ----------------------------------------------------------------------
  wire [NUM_CELLS-1:0] v_onehot = NUM_CELLS'(1) << v_ch_r;
  wire [NUM_GPIO-1:0] t_onehot = NUM_GPIO'(1) << t_ch_r;
  wire v_path_act = (v_st_r == ST_PATH) && cell_active_in[v_ch_r];
  wire v_path_chk = v_path_act && v_ph_r;
  wire v_force_chk = (v_st_r == ST_FORCE) && v_ph_r;
  wire t_path_chk = (t_st_r == ST_PATH) && t_ph_r;
  wire t_force_chk = (t_st_r == ST_FORCE) && t_ph_r;
  wire v_clr_ch = v_ph_r && !keep_r;
  wire t_clr_ch = t_ph_r && !keep_r;
  wire v_rr = (v_run_r == MODE_RR) || (v_run_r == MODE_SINGLE);
  wire t_rr = (t_run_r == MODE_RR) || (t_run_r == MODE_SINGLE);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      uv_bits_r <= '0;
      ov_bits_r <= '0;
      ut_bits_r <= '0;
      ot_bits_r <= '0;
    end else begin
      if (v_rr && !v_bist) begin
        uv_bits_r <= uv_bits_r | cell_uv_in;
        ov_bits_r <= ov_bits_r | cell_ov_in;
      end else if (v_st_r == ST_PATH && v_path_act) begin
        if (!v_ph_r) uv_bits_r <= uv_bits_r | (v_onehot & cell_uv_in);
        else if (v_clr_ch) uv_bits_r <= uv_bits_r & ~v_onehot;
      end else if (v_st_r == ST_FORCE) begin
        // force OV bits one by one
        if (!v_ph_r) ov_bits_r <= ov_bits_r | v_onehot;
        else if (v_clr_ch) ov_bits_r <= ov_bits_r & ~v_onehot;
      end
      if (t_rr && !t_bist) begin
        ut_bits_r <= ut_bits_r | gpio_ut_in;
        ot_bits_r <= ot_bits_r | gpio_ot_in;
      end else if (t_st_r == ST_PATH) begin
        if (!t_ph_r) ut_bits_r <= ut_bits_r | (t_onehot & gpio_ut_in);
        else if (t_clr_ch) ut_bits_r <= ut_bits_r & ~t_onehot;
      end else if (t_st_r == ST_FORCE) begin
        // force OT bits one by one
        if (!t_ph_r) ot_bits_r <= ot_bits_r | t_onehot;
        else if (t_clr_ch) ot_bits_r <= ot_bits_r & ~t_onehot;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fail flags: set wins over software clear
  // ----------------------------------------------------------------------
  wire [1:0] set_a = {t_par_bad, v_par_bad};
  wire v_cmp = (v_st_r == ST_COMP);
  wire t_cmp = (t_st_r == ST_COMP);
  wire v_path_fail = (v_path_chk && !(uv_bits_r[v_ch_r] && fault_output_low_oe_out))
    || (v_force_chk && !(ov_bits_r[v_ch_r] && fault_output_low_oe_out));
  wire t_path_fail = (t_path_chk && !(ut_bits_r[t_ch_r] && fault_output_low_oe_out))
    || (t_force_chk && !(ot_bits_r[t_ch_r] && fault_output_low_oe_out));
  wire abort_set = ((v_st_r == ST_PRE) || (t_st_r == ST_PRE)) && fault_seen_in;
  wire [6:0] set_b;
  assign set_b = {abort_set, t_path_fail, v_path_fail,
                  t_cmp && !cmp_ok_in[3], t_cmp && !cmp_ok_in[2],
                  v_cmp && !cmp_ok_in[1], v_cmp && !cmp_ok_in[0]};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_a_r <= 2'h0;
      stat_b_r <= 7'h00;
    end else begin
      stat_a_r <= (fail_clr ? 2'h0 : stat_a_r) | set_a;
      stat_b_r <= (fail_clr ? 7'h00 : stat_b_r) | set_b;
    end
  end

  // ----------------------------------------------------------------------
  // Pins toward the analog front end and fault output
  // ----------------------------------------------------------------------
  // Open-drain: enable pulls the line low while any fault bit stands
  assign fault_output_low_out = 1'b0;
  assign fault_output_low_oe_out = fault_any;
  assign cell_open_out = (v_st_r == ST_PATH) ? (v_onehot & cell_active_in) : '0;
  assign gpio_pullup_out = (t_st_r == ST_PATH) ? t_onehot : '0;
  assign cmp_test_out = {t_cmp, t_cmp, v_cmp, v_cmp};
  assign cmp_on_out = {t_en || t_bist, v_en || v_bist};

  wire [THR_W+2:0] ov_sc = (THR_W+3)'(ov_thr_r) * (THR_W+3)'(DAC_SCALE_NUM);
  wire [THR_W+2:0] uv_sc = (THR_W+3)'(uv_thr_r) * (THR_W+3)'(DAC_SCALE_NUM);
  wire [THR_W+2:0] ov_dac = ov_sc / (THR_W+3)'(DAC_SCALE_DEN);
  wire [THR_W+2:0] uv_dac = uv_sc / (THR_W+3)'(DAC_SCALE_DEN);
  wire [THR_W-1:0] dac_mux = (dac_sel_r == 2'h0) ? ov_dac[THR_W-1:0] :
                             (dac_sel_r == 2'h1) ? uv_dac[THR_W-1:0] :
                             (dac_sel_r == 2'h2) ? ot_thr_r : ut_thr_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) aux_dac_out <= THR_RST;
    else aux_dac_out <= dac_mux;
  end

  // ----------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (bus.addr)
      ADDR_VCTRL: rd_mux = {25'h0, vctrl_r};
      ADDR_TCTRL: rd_mux = {25'h0, tctrl_r};
      ADDR_DIAG: rd_mux = {31'h0, keep_r};
      ADDR_OV_THR: rd_mux = {24'h0, ov_thr_r};
      ADDR_UV_THR: rd_mux = {24'h0, uv_thr_r};
      ADDR_OT_THR: rd_mux = {24'h0, ot_thr_r};
      ADDR_UT_THR: rd_mux = {24'h0, ut_thr_r};
      ADDR_STAT_A: rd_mux = {30'h0, stat_a_r};
      ADDR_STAT_B: rd_mux = {25'h0, stat_b_r};
      ADDR_UV_BITS: rd_mux = {16'h0, uv_bits_r};
      ADDR_OV_BITS: rd_mux = {16'h0, ov_bits_r};
      ADDR_UTOT_BITS: rd_mux = {16'h0, ot_bits_r, ut_bits_r};
      ADDR_DAC_RB: rd_mux = {24'h0, aux_dac_out};
      ADDR_DAC_SEL: rd_mux = {30'h0, dac_sel_r};
      default: rd_mux = RD_ZERO;
    endcase
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) rdata_out <= RD_ZERO;
    else rdata_out <= bus.rd ? rd_mux : RD_ZERO;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_vgo_bist;
    v_go && (v_mode_w == MODE_BIST);
  endsequence
  property p_vstart;
    @(posedge clk_in) disable iff (rst_in) s_vgo_bist |=> (v_st_r == ST_COMP) ##1 v_st_r == ST_PRE;
  endproperty
  a_vstart: assert property (p_vstart) else $error("voltage self-test did not start");
  property p_tstart;
    @(posedge clk_in) disable iff (rst_in) t_start |=> (t_st_r == ST_COMP);
  endproperty
  a_tstart: assert property (p_tstart) else $error("temperature self-test did not start");
  property p_vpar;
    @(posedge clk_in) disable iff (rst_in) v_par_bad |=> stat_a_r[SA_VPAR_BIT];
  endproperty
  a_vpar: assert property (p_vpar) else $error("voltage parity flag missed");
  property p_abort;
    @(posedge clk_in) disable iff (rst_in)
      (v_st_r == ST_PRE) && fault_seen_in |=> stat_b_r[SB_ABORT_BIT] && v_st_r == ST_DONE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged");
  property p_vdone_off;
    @(posedge clk_in) disable iff (rst_in) v_done && !v_go |=> !cmp_on_out[0];
  endproperty
  a_vdone_off: assert property (p_vdone_off) else $error("comparators left on");
  property p_go_now;
    @(posedge clk_in) disable iff (rst_in) v_go && v_bist && !v_start |=> v_st_r == ST_IDLE;
  endproperty
  a_go_now: assert property (p_go_now) else $error("go not acted on");
  property p_ovcmp;
    @(posedge clk_in) disable iff (rst_in) v_cmp && !cmp_ok_in[0] |=> stat_b_r[SB_OVC_BIT];
  endproperty
  a_ovcmp: assert property (p_ovcmp) else $error("ov comparator fail lost");
  property p_keep;
    @(posedge clk_in) disable iff (rst_in)
      v_force_chk && keep_r && !v_go |=> ov_bits_r[$past(v_ch_r)];
  endproperty
  a_keep: assert property (p_keep) else $error("fault bit cleared under keep");
  property p_dac;
    @(posedge clk_in) disable iff (rst_in)
      dac_sel_r == 2'h0 |=> aux_dac_out == 8'(($past(ov_thr_r) * 4) / 5);
  endproperty
  a_dac: assert property (p_dac) else $error("dac readback scale wrong");
endmodule
